// *** design/vwc_pkg.sv ***
`default_nettype none

package vwc_pkg;

  // register indices on the indexed port
  localparam logic [7:0] IDX_VSTART_LO = 8'h37;  // vertical start low
  localparam logic [7:0] IDX_VEND_LO   = 8'h38;  // vertical end low
  localparam logic [7:0] IDX_VOVF      = 8'h39;  // vertical overflow
  localparam logic [7:0] IDX_ADDR_B0   = 8'h3A;  // start address byte 0
  localparam logic [7:0] IDX_ADDR_B1   = 8'h3B;  // start address byte 1
  localparam logic [7:0] IDX_ADDR_HI   = 8'h3C;  // start address high
  localparam logic [7:0] IDX_PITCH     = 8'h3D;  // line pitch
  localparam logic [7:0] IDX_MASTER    = 8'h3E;  // master control
  localparam logic [7:0] IDX_HVPATH    = 8'h3F;  // host video path control

  // writable masks (reserved bits read zero)
  localparam logic [7:0] MASK_VOVF   = 8'h0F;  // bits 3:0
  localparam logic [7:0] MASK_ADDRHI = 8'h37;  // bits 5,4,2:0
  localparam logic [7:0] MASK_HVPATH = 8'h5B;  // bits 6,4,3,1,0

  // field positions
  localparam int VOVF_VS_LSB  = 0;  // start bits 9:8
  localparam int VOVF_VE_LSB  = 2;  // end bits 9:8
  localparam int AHI_PITCH9   = 5;  // pitch bit 9
  localparam int AHI_THRESH   = 4;  // fifo threshold select
  localparam int MC_OCCLUDE   = 7;  // occlusion enable
  localparam int MC_BLANK     = 6;  // window blank
  localparam int MC_DIFFUSE   = 5;  // error diffusion
  localparam int MC_VZOOM     = 4;  // vertical zoom mode
  localparam int MC_FMT_LSB   = 1;  // format bits 3:1
  localparam int MC_ENABLE    = 0;  // master enable
  localparam int HV_VSYNC     = 7;  // vsync level
  localparam int HV_FIELD     = 6;  // field / polarity
  localparam int HV_ENC_LSB   = 3;  // encode bits 4:3
  localparam int HV_ERR       = 2;  // protocol error flag
  localparam int HV_CHECK     = 1;  // check enable
  localparam int HV_PAGE      = 0;  // page select

  // reset values
  localparam logic [7:0] RESET_REG    = 8'h00;  // all window registers
  localparam logic [7:0] RESET_HIDDEN = 8'h00;  // hidden palette mode

  // capture control value that enables capture
  localparam logic [1:0] CAPTURE_ON = 2'h3;

  // fifo thresholds (plain defaults)
  localparam logic [3:0] FIFO_THRESH_DEFAULT = 4'h8;  // default level
  localparam logic [3:0] FIFO_THRESH_SMALL   = 4'h4;  // reduced level

  // window formats
  typedef enum logic [2:0] {
    VWC_FMT_YUV_EX128  = 3'h0,
    VWC_FMT_CMP_EX128  = 3'h1,
    VWC_FMT_RESERVED   = 3'h2,
    VWC_FMT_CMP_RGB    = 3'h3,
    VWC_FMT_RGB555     = 3'h4,
    VWC_FMT_RGB565     = 3'h5,
    VWC_FMT_YUV_TWOS   = 3'h6,
    VWC_FMT_CMP_TWOS   = 3'h7
  } vwc_fmt_t;

  // encode source selection
  typedef enum logic [1:0] {
    VWC_ENC_OFF    = 2'h0,
    VWC_ENC_YUV422 = 2'h1,
    VWC_ENC_RGB555 = 2'h2
  } vwc_enc_t;

  // window enable state machine, one-hot
  typedef enum logic [2:0] {
    VWC_ST_OFF  = 3'h1,
    VWC_ST_ARM  = 3'h2,
    VWC_ST_ON   = 3'h4
  } vwc_state_t;

  // decoded controls for the display path
  typedef struct packed {
    logic     occlude;
    logic     blank;
    logic     diffuse;
    logic     zoom_replicate;
    vwc_fmt_t fmt;
    vwc_enc_t enc;
  } vwc_mode_t;

endpackage : vwc_pkg

`default_nettype wire

// *** design/vwc_top.sv ***
`timescale 1ns/1ps
`default_nettype none

module vwc_top (
  input  wire logic        clk,              // 10 MHz clock
  input  wire logic        reset_n,          // async reset, active low
  input  wire logic [7:0]  reg_index,        // indexed port register index
  input  wire logic [7:0]  reg_wdata,        // write data
  input  wire logic        reg_wr,           // write strobe
  output logic      [7:0]  reg_rdata,        // read data, registered
  input  wire logic        hidden_wr,        // hidden palette mode write
  output logic      [7:0]  hidden_palette_mode, // hidden palette mode value
  input  wire logic        crt_vsync,        // display vsync level
  input  wire logic        line_end,         // end-of-scanline pulse
  input  wire logic [9:0]  scanline,         // current scanline number
  input  wire logic        pixel_key,        // per-pixel overlay key
  input  wire logic        pixel_in_rect,    // pixel inside window columns
  input  wire logic [1:0]  capture_control,  // capture control field
  input  wire logic        video_port_vsync_in, // video port vsync
  input  wire logic        video_field_in,   // raw odd/even field
  input  wire logic        addr_protocol_violation, // protocol error pulse
  output logic             win_active,       // window enabled
  output logic             win_line,         // scanline inside window
  output logic             overlay_pixel,    // show overlay at pixel
  output logic             force_black,      // window pixel forced black
  output logic      [18:0] win_addr,         // running window line address
  output logic      [3:0]  fifo_threshold,   // video fifo threshold
  output vwc_pkg::vwc_mode_t mode,           // decoded mode
  output logic             video_page_select, // address page bit
  output logic             field_out         // field after polarity
);

  ////////////////////////////////////////////////////////////////////////////
  // register storage

  logic [7:0] window_vertical_start_low;   // start low byte
  logic [7:0] window_vertical_end_low;     // end low byte
  logic [7:0] window_vertical_overflow;    // high bits
  logic [7:0] window_start_address_byte0; // address 7:0
  logic [7:0] window_start_address_byte1; // address 15:8
  logic [7:0] window_start_address_high;  // address 18:16, pitch 9, thresh
  logic [7:0] window_line_pitch;           // pitch 8:1
  logic [7:0] window_master_control;       // master control
  logic [7:0] host_video_path_control;     // writable part of path control
  logic       addr_protocol_error_flag;    // sticky error
  vwc_pkg::vwc_state_t state;              // enable state
  vwc_pkg::vwc_state_t next_state;         // next enable state
  logic       vsync_q;                     // vsync delayed for edge detect
  logic       vsync_rise;                  // leading vsync edge
  logic [9:0] win_vstart;                  // full vertical start
  logic [9:0] win_vend;                    // full vertical end
  logic [9:0] pitch;                       // full line pitch
  logic [18:0] start_addr;                 // full start address
  logic       check_enable;                // protocol checking on

  // software register writes
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      window_vertical_start_low  <= vwc_pkg::RESET_REG;
      window_vertical_end_low    <= vwc_pkg::RESET_REG;
      window_vertical_overflow   <= vwc_pkg::RESET_REG;
      window_start_address_byte0 <= vwc_pkg::RESET_REG;
      window_start_address_byte1 <= vwc_pkg::RESET_REG;
      window_start_address_high  <= vwc_pkg::RESET_REG;
      window_line_pitch          <= vwc_pkg::RESET_REG;
      window_master_control      <= vwc_pkg::RESET_REG;
      host_video_path_control    <= vwc_pkg::RESET_REG;
    end
    else if (reg_wr)
    begin
      case (reg_index)
        vwc_pkg::IDX_VSTART_LO: window_vertical_start_low <= reg_wdata;
        vwc_pkg::IDX_VEND_LO:   window_vertical_end_low   <= reg_wdata;
        // reserved bits dropped
        vwc_pkg::IDX_VOVF:    window_vertical_overflow <= reg_wdata & vwc_pkg::MASK_VOVF;
        vwc_pkg::IDX_ADDR_B0: window_start_address_byte0 <= reg_wdata;
        vwc_pkg::IDX_ADDR_B1: window_start_address_byte1 <= reg_wdata;
        vwc_pkg::IDX_ADDR_HI: window_start_address_high <= reg_wdata & vwc_pkg::MASK_ADDRHI;
        vwc_pkg::IDX_PITCH:   window_line_pitch <= reg_wdata;
        vwc_pkg::IDX_MASTER:  window_master_control <= reg_wdata;
        vwc_pkg::IDX_HVPATH:  host_video_path_control <= reg_wdata & vwc_pkg::MASK_HVPATH;
        default:              ; // other indices belong elsewhere
      endcase
    end
  end

  // hidden palette mode register
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      hidden_palette_mode <= vwc_pkg::RESET_HIDDEN;
    else if (hidden_wr)
      hidden_palette_mode <= reg_wdata;
  end

  ////////////////////////////////////////////////////////////////////////////
  // field assembly

  assign win_vstart = {window_vertical_overflow[vwc_pkg::VOVF_VS_LSB +: 2],
                       window_vertical_start_low};
  assign win_vend   = {window_vertical_overflow[vwc_pkg::VOVF_VE_LSB +: 2],
                       window_vertical_end_low};
  assign start_addr = {window_start_address_high[2:0], window_start_address_byte1,
                       window_start_address_byte0};
  assign pitch      = {window_start_address_high[vwc_pkg::AHI_PITCH9],
                       window_line_pitch, 1'b0};
  assign check_enable = host_video_path_control[vwc_pkg::HV_CHECK];

  ////////////////////////////////////////////////////////////////////////////
  // enable sequencing

  // vsync edge detector
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      vsync_q <= 1'b0;
    else
      vsync_q <= crt_vsync;
  end

  assign vsync_rise = crt_vsync && !vsync_q;

  // next enable state
  always_comb
  begin
    next_state = state;
    case (state)
      vwc_pkg::VWC_ST_OFF:
      begin
        if (window_master_control[vwc_pkg::MC_ENABLE])
          next_state = vsync_rise ? vwc_pkg::VWC_ST_ON : vwc_pkg::VWC_ST_ARM;
      end
      vwc_pkg::VWC_ST_ARM:
      begin
        if (!window_master_control[vwc_pkg::MC_ENABLE])
          next_state = vwc_pkg::VWC_ST_OFF;
        else if (vsync_rise)
          next_state = vwc_pkg::VWC_ST_ON;
      end
      vwc_pkg::VWC_ST_ON:
      begin
        if (!window_master_control[vwc_pkg::MC_ENABLE])
          next_state = vwc_pkg::VWC_ST_OFF;
      end
      default: next_state = vwc_pkg::VWC_ST_OFF;
    endcase
  end

  // enable state register
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      state <= vwc_pkg::VWC_ST_OFF;
    else
      state <= next_state;
  end

  // window on; drop at once when the enable bit clears
  assign win_active = (state == vwc_pkg::VWC_ST_ON) &&
                      window_master_control[vwc_pkg::MC_ENABLE];

  // off or armed stays dark until a leading vsync edge
  arm_wait_a: assert property (@(posedge clk) disable iff (!reset_n)
    (!win_active && !vsync_rise) |=> !win_active)
    else $error("window turned on while waiting for vsync");

  ////////////////////////////////////////////////////////////////////////////
  // vertical extent and line address

  // inclusive start and end scanlines
  assign win_line = win_active && (scanline >= win_vstart) && (scanline <= win_vend);

  // running address: start at top of window, step by pitch per window line
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      win_addr <= 19'h00000;
    else if (!win_line)
      win_addr <= start_addr;
    else if (line_end)
      win_addr <= win_addr + {9'h000, pitch};
  end

  // outside the window the address sits at the start address
  addr_reload_a: assert property (@(posedge clk) disable iff (!reset_n)
    !win_line |=> win_addr == $past(start_addr))
    else $error("window address not reloaded");

  ////////////////////////////////////////////////////////////////////////////
  // pixel and mode controls

  // occlusion picks per-pixel key, else window rectangle
  assign overlay_pixel = win_line && (window_master_control[vwc_pkg::MC_OCCLUDE] ?
                         pixel_key : pixel_in_rect);
  assign force_black = overlay_pixel && window_master_control[vwc_pkg::MC_BLANK];

  // mode decode for the conversion path
  always_comb
  begin
    mode.occlude        = window_master_control[vwc_pkg::MC_OCCLUDE];
    mode.blank          = window_master_control[vwc_pkg::MC_BLANK];
    mode.diffuse        = window_master_control[vwc_pkg::MC_DIFFUSE];
    mode.zoom_replicate = window_master_control[vwc_pkg::MC_VZOOM];
    mode.fmt = vwc_pkg::vwc_fmt_t'(window_master_control[vwc_pkg::MC_FMT_LSB +: 3]);
    case (host_video_path_control[vwc_pkg::HV_ENC_LSB +: 2])
      2'h2:    mode.enc = vwc_pkg::VWC_ENC_YUV422;
      2'h3:    mode.enc = vwc_pkg::VWC_ENC_RGB555;
      default: mode.enc = vwc_pkg::VWC_ENC_OFF;
    endcase
  end

  // fifo threshold under capture
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      fifo_threshold <= vwc_pkg::FIFO_THRESH_DEFAULT;
    else if (capture_control == vwc_pkg::CAPTURE_ON &&
             window_start_address_high[vwc_pkg::AHI_THRESH])
      fifo_threshold <= vwc_pkg::FIFO_THRESH_SMALL;
    else
      fifo_threshold <= vwc_pkg::FIFO_THRESH_DEFAULT;
  end

  // default level whenever the small level is not asked for
  thresh_dflt_a: assert property (@(posedge clk) disable iff (!reset_n)
    !(capture_control == vwc_pkg::CAPTURE_ON &&
      window_start_address_high[vwc_pkg::AHI_THRESH]) |=>
      fifo_threshold == vwc_pkg::FIFO_THRESH_DEFAULT)
    else $error("default threshold not selected");

  ////////////////////////////////////////////////////////////////////////////
  // host video path status

  // sticky error, set wins inside checking, cleared while checking off
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      addr_protocol_error_flag <= 1'b0;
    else if (!check_enable)
      addr_protocol_error_flag <= 1'b0;
    else if (addr_protocol_violation)
      addr_protocol_error_flag <= 1'b1;
  end

  // field polarity and page bit
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      field_out         <= 1'b0;
      video_page_select <= 1'b0;
    end
    else
    begin
      field_out         <= video_field_in ^ host_video_path_control[vwc_pkg::HV_FIELD];
      video_page_select <= host_video_path_control[vwc_pkg::HV_PAGE];
    end
  end

  // field output follows the raw field through the polarity bit
  field_pol_a: assert property (@(posedge clk) disable iff (!reset_n)
    $past(reset_n) |-> field_out ==
      ($past(video_field_in) ^ $past(host_video_path_control[vwc_pkg::HV_FIELD])))
    else $error("field output ignores polarity");

  ////////////////////////////////////////////////////////////////////////////
  // register read

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      reg_rdata <= 8'h00;
    else
    begin
      case (reg_index)
        vwc_pkg::IDX_VSTART_LO: reg_rdata <= window_vertical_start_low;
        vwc_pkg::IDX_VEND_LO:   reg_rdata <= window_vertical_end_low;
        vwc_pkg::IDX_VOVF:      reg_rdata <= window_vertical_overflow;
        vwc_pkg::IDX_ADDR_B0:   reg_rdata <= window_start_address_byte0;
        vwc_pkg::IDX_ADDR_B1:   reg_rdata <= window_start_address_byte1;
        vwc_pkg::IDX_ADDR_HI:   reg_rdata <= window_start_address_high;
        vwc_pkg::IDX_PITCH:     reg_rdata <= window_line_pitch;
        vwc_pkg::IDX_MASTER:    reg_rdata <= window_master_control;
        vwc_pkg::IDX_HVPATH:
          reg_rdata <= {video_port_vsync_in, field_out, 1'b0,
                        host_video_path_control[4:3], addr_protocol_error_flag,
                        host_video_path_control[1:0]};
        default:                reg_rdata <= 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  // enable only follows a vsync leading edge
  enable_at_vsync_a: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(win_active) |-> $past(vsync_rise))
    else $error("window turned on without vsync edge");

  // disable takes effect at once and the state machine leaves on
  disable_now_a: assert property (@(posedge clk) disable iff (!reset_n)
    !window_master_control[vwc_pkg::MC_ENABLE] |->
      !win_active ##1 (state != vwc_pkg::VWC_ST_ON))
    else $error("window still on after disable");

  // window line bounds
  vert_bounds_a: assert property (@(posedge clk) disable iff (!reset_n)
    win_line |-> (scanline >= win_vstart && scanline <= win_vend))
    else $error("window line outside vertical bounds");

  vert_end_a: assert property (@(posedge clk) disable iff (!reset_n)
    (win_active && scanline == win_vend && win_vstart <= win_vend) |-> win_line)
    else $error("last scanline not in window");

  // pitch stepping
  pitch_step_a: assert property (@(posedge clk) disable iff (!reset_n)
    (win_line && line_end) ##1 win_line |->
      win_addr == 19'($past(win_addr) + {9'h000, $past(pitch)}))
    else $error("window address did not step by pitch");

  // a pitch step never moves the address low bit
  pitch_lsb_a: assert property (@(posedge clk) disable iff (!reset_n)
    (win_line && line_end) ##1 win_line |->
      win_addr[0] == $past(win_addr[0]) && pitch[9] == window_start_address_high[5])
    else $error("pitch low bit not zero");

  // error flag behaviour
  err_clear_a: assert property (@(posedge clk) disable iff (!reset_n)
    !check_enable |=> !addr_protocol_error_flag)
    else $error("error flag not cleared");

  err_sticky_a: assert property (@(posedge clk) disable iff (!reset_n)
    (addr_protocol_error_flag && check_enable) |=> addr_protocol_error_flag)
    else $error("error flag dropped while checking");

  err_set_a: assert property (@(posedge clk) disable iff (!reset_n)
    (check_enable && addr_protocol_violation) |=> addr_protocol_error_flag)
    else $error("error flag not set on violation");

  // blanking and threshold
  blank_black_a: assert property (@(posedge clk) disable iff (!reset_n)
    (overlay_pixel && window_master_control[6]) |-> force_black)
    else $error("window pixel not blanked");

  thresh_sel_a: assert property (@(posedge clk) disable iff (!reset_n)
    (capture_control == 2'h3 && window_start_address_high[4]) |=>
      fifo_threshold == vwc_pkg::FIFO_THRESH_SMALL)
    else $error("small threshold not selected");

endmodule : vwc_top

`default_nettype wire

// *** dv/vwc_tb.sv ***
`timescale 1ns/1ps
`default_nettype none

module testbench;
  // row of the register table: index, write value, value read back
  typedef struct packed {
    logic [7:0] idx;    // register index
    logic [7:0] wdata;  // value written
    logic [7:0] rexp;   // value expected back
  } vwc_row_t;

  logic        clk;              // 10 MHz clock
  logic        reset_n;          // async reset, active low
  logic [7:0]  reg_index;        // register index
  logic [7:0]  reg_wdata;        // write data
  logic        reg_wr;           // write strobe
  logic [7:0]  reg_rdata;        // read data
  logic        hidden_wr;        // hidden register strobe
  logic [7:0]  hidden_palette_mode; // hidden register value
  logic        crt_vsync;        // display vsync
  logic        line_end;         // end of scanline
  logic [9:0]  scanline;         // scanline number
  logic        pixel_key;        // per-pixel key
  logic        pixel_in_rect;    // pixel inside columns
  logic [1:0]  capture_control;  // capture field
  logic        video_port_vsync_in; // video port vsync
  logic        video_field_in;   // raw field
  logic        addr_protocol_violation; // protocol error pulse
  logic        win_active;       // window enabled
  logic        win_line;         // scanline inside window
  logic        overlay_pixel;    // overlay shown
  logic        force_black;      // pixel blanked
  logic [18:0] win_addr;         // line address
  logic [3:0]  fifo_threshold;   // fifo level
  vwc_pkg::vwc_mode_t mode;      // decoded mode
  logic        video_page_select; // page bit
  logic        field_out;        // field after polarity
  int          failures;         // mismatches
  int          samples_checked;  // comparisons made
  logic [3:0]  k;                // loop index
  vwc_row_t    rows [9];         // register table
  logic [1:0]  enc_exp [4];      // expected encode per field value
  logic [10:0] lines [4];        // scanline and expected in-window flag

  vwc_top i_dut (
    .clk(clk), .reset_n(reset_n), .reg_index(reg_index), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rdata(reg_rdata), .hidden_wr(hidden_wr),
    .hidden_palette_mode(hidden_palette_mode), .crt_vsync(crt_vsync),
    .line_end(line_end), .scanline(scanline), .pixel_key(pixel_key),
    .pixel_in_rect(pixel_in_rect), .capture_control(capture_control),
    .video_port_vsync_in(video_port_vsync_in), .video_field_in(video_field_in),
    .addr_protocol_violation(addr_protocol_violation), .win_active(win_active),
    .win_line(win_line), .overlay_pixel(overlay_pixel), .force_black(force_black),
    .win_addr(win_addr), .fifo_threshold(fifo_threshold), .mode(mode),
    .video_page_select(video_page_select), .field_out(field_out)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // clock, 100 ns period
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // hang guard, run needs well under a thousand cycles
  initial
  begin
    repeat (5000) @(posedge clk);
    failures++;
    final_report();
  end

  ////////////////////////////////////////////////////////////////////////////////
  // compare helper, case equality so unknowns fail
  task automatic chk(input logic [18:0] got, input logic [18:0] exp, input string what);
    samples_checked++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  // let n edges pass, then settle
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  // one-cycle write strobe on the indexed port
  task automatic wr(input logic [7:0] idx, input logic [7:0] data);
    @(posedge clk);
    reg_index <= idx;
    reg_wdata <= data;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask : wr

  // present index, read data is registered one cycle later
  task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
    @(posedge clk);
    reg_index <= idx;
    tick(2);
    chk(reg_rdata, exp, "register read");
  endtask : rd

  // one-cycle pulse on an input
  task automatic pulse_line();
    @(posedge clk);
    line_end <= 1'b1;
    @(posedge clk);
    line_end <= 1'b0;
  endtask : pulse_line

  // verdict, the only end of the run
  task automatic final_report();
    $display("failures %0d samples_checked %0d", failures, samples_checked);
    if (failures == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : final_report

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    failures = 0; samples_checked = 0;
    reset_n = 1'b0; reg_index = 8'h00; reg_wdata = 8'h00; reg_wr = 1'b0;
    hidden_wr = 1'b0; crt_vsync = 1'b0; line_end = 1'b0; scanline = 10'h000;
    pixel_key = 1'b0; pixel_in_rect = 1'b0; capture_control = 2'h0;
    video_port_vsync_in = 1'b0; video_field_in = 1'b0; addr_protocol_violation = 1'b0;
    // start 0x010, end 0x112, address 0x53412, pitch 0x302
    rows = '{'{8'h37, 8'h10, 8'h10}, '{8'h38, 8'h12, 8'h12}, '{8'h39, 8'hF4, 8'h04},
             '{8'h3A, 8'h12, 8'h12}, '{8'h3B, 8'h34, 8'h34}, '{8'h3C, 8'hFD, 8'h35},
             '{8'h3D, 8'h81, 8'h81}, '{8'h3E, 8'hFE, 8'hFE}, '{8'h3F, 8'hFF, 8'h5B}};
    enc_exp = '{2'h0, 2'h0, 2'h1, 2'h2};
    lines = '{{10'h00F, 1'b0}, {10'h010, 1'b1}, {10'h112, 1'b1}, {10'h113, 1'b0}};
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    // reset values
    chk(hidden_palette_mode, 19'h00000, "hidden reset");
    chk(fifo_threshold, vwc_pkg::FIFO_THRESH_DEFAULT, "fifo reset");
    for (int i = 0; i < 9; i++) rd(rows[i].idx, 8'h00);
    // stray write to an unmapped index, then the table
    wr(8'h36, 8'hFF);
    for (int i = 0; i < 9; i++) wr(rows[i].idx, rows[i].wdata);
    for (int i = 0; i < 9; i++) rd(rows[i].idx, rows[i].rexp);
    chk(mode, 19'h001FE, "mode decode");
    chk(win_addr, 19'h53412, "start address");
    chk(video_page_select, 19'h00001, "page bit");
    chk(fifo_threshold, vwc_pkg::FIFO_THRESH_DEFAULT, "fifo capture off");
    capture_control <= 2'h3;
    tick(2);
    chk(fifo_threshold, vwc_pkg::FIFO_THRESH_SMALL, "fifo capture on");
    // every format and encode code
    for (k = 4'h0; k < 4'h8; k++)
    begin
      wr(vwc_pkg::IDX_MASTER, {4'h0, k[2:0], 1'b0});
      tick(1);
      chk(mode.fmt, k[2:0], "format field");
    end
    for (k = 4'h0; k < 4'h4; k++)
    begin
      wr(vwc_pkg::IDX_HVPATH, {3'h0, k[1:0], 3'h0});
      tick(1);
      chk(mode.enc, enc_exp[k[1:0]], "encode field");
    end
    // enable waits for the vsync leading edge
    wr(vwc_pkg::IDX_MASTER, 8'h01);
    tick(3);
    chk(win_active, 19'h00000, "enable before vsync");
    crt_vsync <= 1'b1;
    tick(2);
    chk(win_active, 19'h00001, "enable after vsync");
    crt_vsync <= 1'b0;
    // vertical bounds, each edge and the line just outside it
    for (int i = 0; i < 4; i++)
    begin
      scanline <= lines[i][10:1];
      tick(2);
      chk(win_line, lines[i][0], "window line");
    end
    // line address steps by the pitch at each line end
    scanline <= 10'h00F;
    tick(2);
    chk(win_addr, 19'h53412, "address reload");
    scanline <= 10'h010;
    pulse_line();
    tick(1);
    chk(win_addr, 19'h53714, "address plus pitch");
    pulse_line();
    tick(1);
    chk(win_addr, 19'h53A16, "address plus two pitches");
    // rectangle overlay, no blank
    pixel_in_rect <= 1'b1;
    tick(2);
    chk({overlay_pixel, force_black}, 19'h00002, "rect overlay");
    // per-pixel overlay with blank
    wr(vwc_pkg::IDX_MASTER, 8'hC1);
    tick(1);
    chk({overlay_pixel, force_black}, 19'h00000, "key low");
    pixel_key <= 1'b1;
    pixel_in_rect <= 1'b0;
    tick(2);
    chk({overlay_pixel, force_black}, 19'h00003, "key high blanked");
    // disable takes effect at once
    wr(vwc_pkg::IDX_MASTER, 8'h00);
    #1;
    chk(win_active, 19'h00000, "disable immediate");
    // sticky protocol error, vsync level and field readback
    video_port_vsync_in <= 1'b1;
    video_field_in <= 1'b1;
    wr(vwc_pkg::IDX_HVPATH, 8'h02);
    @(posedge clk);
    addr_protocol_violation <= 1'b1;
    @(posedge clk);
    addr_protocol_violation <= 1'b0;
    rd(vwc_pkg::IDX_HVPATH, 8'hC6);
    wr(vwc_pkg::IDX_HVPATH, 8'h00);
    @(posedge clk);
    addr_protocol_violation <= 1'b1;
    @(posedge clk);
    addr_protocol_violation <= 1'b0;
    rd(vwc_pkg::IDX_HVPATH, 8'hC0);
    wr(vwc_pkg::IDX_HVPATH, 8'h42);
    tick(2);
    chk(field_out, 19'h00000, "field inverted");
    rd(vwc_pkg::IDX_HVPATH, 8'h82);
    // hidden register, then a second reset
    @(posedge clk);
    reg_wdata <= 8'h5A;
    hidden_wr <= 1'b1;
    @(posedge clk);
    hidden_wr <= 1'b0;
    tick(1);
    chk(hidden_palette_mode, 19'h0005A, "hidden write");
    reset_n <= 1'b0;
    tick(2);
    chk(hidden_palette_mode, 19'h00000, "hidden second reset");
    @(posedge clk);
    reset_n <= 1'b1;
    rd(vwc_pkg::IDX_ADDR_HI, 8'h00);
    final_report();
  end
endmodule : testbench

`default_nettype wire
